// ---- verilog/irq_pc_control.sv ----
// Operation
// RULE_01: Control holds non-comparator irq bits
// RULE_02: Flags set regardless of enables
// RULE_03: Request needs flag, enable, global and group; code gates only the comparator with group
// RULE_04: Own register for comparator enable
// RULE_05: Own register for comparator flag
// RULE_06: Clear flag before enabling interrupt
// RULE_07: Reset cause bits 7..2 read zero
// RULE_08: Power-on clears bit one; software sets it
// RULE_09: Brown-out clears bit zero; software sets it
// RULE_10: Brown-out flag undefined if detector off
// RULE_11: 13-bit counter, only low byte visible
// RULE_12: Every reset clears the program counter
// RULE_13: Low byte write loads upper from holding
// RULE_14: Call and jump take holding bits 4:3
// RULE_15: Computed jump adds to low byte, no carry
// RULE_16: 8-deep 13-bit stack, hidden pointer
// RULE_17: Call and interrupt entry push the counter
// RULE_18: All three returns pop the stack
// RULE_19: Push and pop leave holding register alone
// RULE_20: Stack wraps, ninth push overwrites first
// RULE_21: No overflow or underflow status
// RULE_22: Port change flag from ORed pin mismatches
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module irq_pc_control
    import irq_pc_pkg::*;
#(
    parameter logic [12:0] VECTOR = IRQ_VECTOR
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output      logic [7:0]                  reg_rdata,
    input  wire logic                        por_event,
    input  wire logic                        bor_event,
    input  wire logic                        other_reset_event,
    input  wire logic                        brownout_detect_config,
    input  wire logic                        timer_overflow_event,
    input  wire logic                        ext_edge_event,
    input  wire logic                        comparator_event,
    input  wire logic [PORT_CHANGE_PINS-1:0] port_pins,
    input  wire logic [PORT_CHANGE_PINS-1:0] port_inputs,
    input  wire logic                        port_read,
    input  wire logic                        pc_step,
    input  wire logic                        branch_en,
    input  wire logic                        call_en,
    input  wire logic [TARGET_WIDTH-1:0]     branch_target,
    input  wire logic                        return_en,
    input  wire logic                        exit_with_literal_instr,
    input  wire logic                        interrupt_exit_instr,
    input  wire logic                        irq_entry,
    input  wire logic                        add_w_to_file_instr,
    input  wire logic [7:0]                  add_value,
    output      logic [PC_WIDTH-1:0]         pc_out,
    output      logic                        irq_request
);

    // State of the unit outside the return stack and the change detector
    typedef struct packed {
        logic [PC_WIDTH-1:0]        pc;
        logic [HIGH_HOLD_WIDTH-1:0] high_hold;
        logic [7:0]                 irq_control;
        logic [7:0]                 periph_flag;
        logic [7:0]                 periph_enable;
        logic [1:0]                 reset_cause;
        logic [7:0]                 rdata;
        logic                       irq;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;
    pc_action_t  pc_action;
    logic        soft_reset;
    logic        any_return;
    logic        wr_low;
    logic        bor_valid;
    logic [7:0]  read_value;
    logic [7:0]  sum_low;

    stack_if #(.WIDTH(PC_WIDTH))               stk ();
    port_change_if #(.PINS(PORT_CHANGE_PINS)) chg ();

    // Address match for write and read paths
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    // Return stack, pointer invisible to software
    return_stack #(
        .WIDTH (PC_WIDTH),
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .clk     (clk),
        .reset_n (reset_n),
        .link    (stk)
    );                                                   // [RULE_16]

    // Upper port pin change detector
    port_change_detect #(
        .PINS (PORT_CHANGE_PINS)
    ) u_change (
        .clk     (clk),
        .reset_n (reset_n),
        .link    (chg)
    );

    // Feed the detector from the port pins
    assign chg.pins        = port_pins;
    assign chg.inputs_mask = port_inputs;
    assign chg.sample      = port_read;

    // Reset sources that act on the clock
    assign soft_reset = por_event | bor_event | other_reset_event;
    assign any_return = return_en | exit_with_literal_instr
                      | interrupt_exit_instr;                // [RULE_18]
    assign wr_low     = reg_write & hit(reg_addr, PC_LOW_OFFSET);
    assign bor_valid  = bor_event & brownout_detect_config;  // [RULE_10]

    // Computed jump sum stays inside the 256-word block
    assign sum_low = state_reg.pc[7:0] + add_value;          // [RULE_15]

    // Pick one program counter action per cycle
    always_comb begin
        if (soft_reset) begin
            pc_action = PC_CLEAR;                            // [RULE_12]
        end else if (irq_entry) begin
            pc_action = PC_VECTOR;
        end else if (call_en) begin
            pc_action = PC_CALL;
        end else if (branch_en) begin
            pc_action = PC_BRANCH;
        end else if (any_return) begin
            pc_action = PC_RETURN;
        end else if (wr_low) begin
            pc_action = PC_LOAD_LOW;
        end else if (add_w_to_file_instr) begin
            pc_action = PC_ADD_LOW;
        end else if (pc_step) begin
            pc_action = PC_STEP;
        end else begin
            pc_action = PC_HOLD;
        end
    end

    // Stack requests; holding register untouched
    assign stk.push      = (pc_action == PC_CALL)
                         | (pc_action == PC_VECTOR);         // [RULE_17]
    assign stk.pop       = (pc_action == PC_RETURN);         // [RULE_18]
    assign stk.push_data = state_reg.pc;                     // [RULE_19]

    // Register read mux; unmapped addresses read zero
    always_comb begin
        read_value = 8'h00;
        if (hit(reg_addr, PC_LOW_OFFSET)) begin
            read_value = state_reg.pc[7:0];                  // [RULE_11]
        end else if (hit(reg_addr, HIGH_HOLD_OFFSET)) begin
            read_value = {3'h0, state_reg.high_hold};
        end else if (hit(reg_addr, IRQ_CONTROL_OFFSET)) begin
            read_value = state_reg.irq_control;              // [RULE_01]
        end else if (hit(reg_addr, PERIPH_FLAG_OFFSET)) begin
            read_value = state_reg.periph_flag;
        end else if (hit(reg_addr, PERIPH_ENABLE_OFFSET)) begin
            read_value = state_reg.periph_enable;
        end else if (hit(reg_addr, RESET_CAUSE_OFFSET)) begin
            read_value = {6'h00, state_reg.reset_cause};     // [RULE_07]
        end
    end

    // Next state: bus writes first, hardware sets win
    always_comb begin
        state_next = state_reg;

        // Read data stand one cycle only
        state_next.rdata = reg_read ? read_value : 8'h00;

        // Software writes
        if (reg_write) begin
            if (hit(reg_addr, HIGH_HOLD_OFFSET)) begin
                state_next.high_hold = reg_wdata[HIGH_HOLD_WIDTH-1:0];
            end
            if (hit(reg_addr, IRQ_CONTROL_OFFSET)) begin
                state_next.irq_control = reg_wdata;          // [RULE_01]
            end
            if (hit(reg_addr, PERIPH_FLAG_OFFSET)) begin
                state_next.periph_flag = reg_wdata;          // [RULE_05]
            end
            if (hit(reg_addr, PERIPH_ENABLE_OFFSET)) begin
                state_next.periph_enable = reg_wdata;        // [RULE_04]
            end
            if (hit(reg_addr, RESET_CAUSE_OFFSET)) begin
                state_next.reset_cause = reg_wdata[1:0];     // [RULE_08]
            end
        end

        // Entry masks interrupts; the exit reopens them
        if (pc_action == PC_VECTOR) begin
            state_next.irq_control[GLOBAL_EN_BIT] = 1'b0;
        end else if (interrupt_exit_instr
                     && pc_action == PC_RETURN) begin
            state_next.irq_control[GLOBAL_EN_BIT] = 1'b1;
        end

        // Flags set whatever the enables say
        if (timer_overflow_event) begin
            state_next.irq_control[TIMER_FLAG_BIT] = 1'b1;   // [RULE_02]
        end
        if (ext_edge_event) begin
            state_next.irq_control[EXT_FLAG_BIT] = 1'b1;     // [RULE_02]
        end
        if (chg.mismatch) begin
            state_next.irq_control[PORT_FLAG_BIT] = 1'b1;    // [RULE_22]
        end
        if (comparator_event) begin
            state_next.periph_flag[COMPARATOR_BIT] = 1'b1;   // [RULE_05]
        end

        // Reset capture beats a software write
        if (por_event) begin
            state_next.reset_cause[POWER_ON_BIT] = 1'b0;     // [RULE_08]
        end
        if (bor_valid) begin
            state_next.reset_cause[BROWNOUT_BIT] = 1'b0;     // [RULE_09]
        end

        // Program counter update
        case (pc_action)
            PC_CLEAR: begin
                state_next.pc = PC_RESET;                    // [RULE_12]
            end
            PC_VECTOR: begin
                state_next.pc = VECTOR;
            end
            PC_CALL, PC_BRANCH: begin
                state_next.pc = {state_reg.high_hold[4:3],
                                 branch_target};             // [RULE_14]
            end
            PC_RETURN: begin
                state_next.pc = stk.top_data;                // [RULE_18]
            end
            PC_LOAD_LOW: begin
                state_next.pc = {state_reg.high_hold,
                                 reg_wdata};                 // [RULE_13]
            end
            PC_ADD_LOW: begin
                state_next.pc = {state_reg.high_hold,
                                 sum_low};                   // [RULE_15]
            end
            PC_STEP: begin
                state_next.pc = state_reg.pc + PC_WIDTH'(1);
            end
            default: begin
                state_next.pc = state_reg.pc;
            end
        endcase

        // Request to the core
        state_next.irq = state_reg.irq_control[GLOBAL_EN_BIT]
            & ((state_reg.irq_control[TIMER_EN_BIT]
                & state_reg.irq_control[TIMER_FLAG_BIT])
             | (state_reg.irq_control[EXT_EN_BIT]
                & state_reg.irq_control[EXT_FLAG_BIT])
             | (state_reg.irq_control[PORT_EN_BIT]
                & state_reg.irq_control[PORT_FLAG_BIT])
             | (state_reg.irq_control[PERIPH_GROUP_BIT]
                & state_reg.periph_enable[COMPARATOR_BIT]
                & state_reg.periph_flag[COMPARATOR_BIT])); // [RULE_03]
    end

    // State register with power-up values
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.pc            <= PC_RESET;             // [RULE_12]
            state_reg.high_hold     <= HIGH_HOLD_RESET;
            state_reg.irq_control   <= IRQ_CONTROL_RESET;
            state_reg.periph_flag   <= PERIPH_RESET;
            state_reg.periph_enable <= PERIPH_RESET;
            state_reg.reset_cause   <= RESET_CAUSE_RESET;    // [RULE_08]
            state_reg.rdata         <= 8'h00;
            state_reg.irq           <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered outputs
    assign reg_rdata   = state_reg.rdata;
    assign pc_out      = state_reg.pc;                       // [RULE_11]
    assign irq_request = state_reg.irq;

endmodule : irq_pc_control

// ---- verilog/irq_pc_pkg.sv ----
package irq_pc_pkg;

    // Register offsets
    localparam logic [7:0] PC_LOW_OFFSET        = 8'h02;
    localparam logic [7:0] HIGH_HOLD_OFFSET     = 8'h0a;
    localparam logic [7:0] IRQ_CONTROL_OFFSET   = 8'h0b;
    localparam logic [7:0] PERIPH_FLAG_OFFSET   = 8'h0c;
    localparam logic [7:0] PERIPH_ENABLE_OFFSET = 8'h8c;
    localparam logic [7:0] RESET_CAUSE_OFFSET   = 8'h8e;

    // Interrupt control bit positions
    localparam int GLOBAL_EN_BIT     = 7;
    localparam int PERIPH_GROUP_BIT  = 6;
    localparam int TIMER_EN_BIT      = 5;
    localparam int EXT_EN_BIT        = 4;
    localparam int PORT_EN_BIT       = 3;
    localparam int TIMER_FLAG_BIT    = 2;
    localparam int EXT_FLAG_BIT      = 1;
    localparam int PORT_FLAG_BIT     = 0;

    // Comparator bit in the peripheral registers
    localparam int COMPARATOR_BIT    = 6;

    // Reset cause bit positions
    localparam int POWER_ON_BIT      = 1;
    localparam int BROWNOUT_BIT      = 0;

    // Widths
    localparam int PC_WIDTH          = 13;
    localparam int HIGH_HOLD_WIDTH   = 5;
    localparam int TARGET_WIDTH      = 11;
    localparam int STACK_DEPTH       = 8;
    localparam int PORT_CHANGE_PINS  = 4;

    // Values after reset
    localparam logic [7:0]  IRQ_CONTROL_RESET   = 8'h00;
    localparam logic [7:0]  PERIPH_RESET        = 8'h00;
    localparam logic [1:0]  RESET_CAUSE_RESET   = 2'h0;
    localparam logic [12:0] PC_RESET            = 13'h0000;
    localparam logic [4:0]  HIGH_HOLD_RESET     = 5'h00;
    localparam logic [12:0] IRQ_VECTOR          = 13'h0004;

    // Program counter actions, highest priority first
    typedef enum logic [3:0] {
        PC_CLEAR,
        PC_VECTOR,
        PC_CALL,
        PC_BRANCH,
        PC_RETURN,
        PC_LOAD_LOW,
        PC_ADD_LOW,
        PC_STEP,
        PC_HOLD
    } pc_action_t;

endpackage : irq_pc_pkg

// ---- verilog/core_links_if.sv ----
`timescale 1ns/1ps

// Link between the control unit and its return stack
interface stack_if #(parameter int WIDTH = 13);
    logic             push;
    logic             pop;
    logic [WIDTH-1:0] push_data;
    logic [WIDTH-1:0] top_data;
    modport owner (output push, output pop, output push_data,
                   input top_data);
    modport store (input push, input pop, input push_data,
                   output top_data);
endinterface : stack_if

// Link between the control unit and the port change detector
interface port_change_if #(parameter int PINS = 4);
    logic [PINS-1:0] pins;
    logic [PINS-1:0] inputs_mask;
    logic            sample;
    logic            mismatch;
    modport owner  (output pins, output inputs_mask, output sample,
                    input mismatch);
    modport detect (input pins, input inputs_mask, input sample,
                    output mismatch);
endinterface : port_change_if

// ---- verilog/return_stack.sv ----
`timescale 1ns/1ps

module return_stack
    import irq_pc_pkg::*;
#(
    parameter int WIDTH = PC_WIDTH,
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic clk,
    input  wire logic reset_n,
    stack_if.store    link
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            ptr;
        logic [WIDTH-1:0]            top;
    } stack_state_t;

    stack_state_t state_reg;
    stack_state_t state_next;

    // Pointer wraps silently, no overflow flag [RULE_21]
    always_comb begin
        state_next = state_reg;
        if (link.push) begin
            state_next.mem[state_reg.ptr] = link.push_data;
            state_next.ptr = state_reg.ptr + PTR_W'(1); // [RULE_20]
            state_next.top = link.push_data;
        end else if (link.pop) begin
            state_next.ptr = state_reg.ptr - PTR_W'(1);
            state_next.top = state_reg.mem[state_reg.ptr - PTR_W'(2)];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.top_data = state_reg.top;

endmodule : return_stack

// ---- verilog/port_change_detect.sv ----
`timescale 1ns/1ps

module port_change_detect
    import irq_pc_pkg::*;
#(
    parameter int PINS = PORT_CHANGE_PINS
) (
    input  wire logic clk,
    input  wire logic reset_n,
    port_change_if.detect link
);
    typedef struct packed {
        logic [PINS-1:0] latched;
        logic            mismatch;
    } change_state_t;

    change_state_t   state_reg;
    change_state_t   state_next;
    logic [PINS-1:0] pin_differs;

    // Per-pin compare, outputs excluded
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        assign pin_differs[i] = link.inputs_mask[i]
                              & (link.pins[i] ^ state_reg.latched[i]);
    end

    // A port read relatches and ends the mismatch
    always_comb begin
        state_next = state_reg;
        if (link.sample) begin
            state_next.latched  = link.pins;
            state_next.mismatch = 1'b0;
        end else begin
            state_next.mismatch = |pin_differs;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.mismatch = state_reg.mismatch;

endmodule : port_change_detect

// ---- testbench/periph_model.sv ----
`timescale 1ns/1ps

module periph_model (
    input  wire logic       clk,
    input  wire logic [2:0] fire,
    output      logic [2:0] events
);
    // Each request becomes a pulse on the next edge
    always_ff @(posedge clk) begin
        events <= fire;
    end
endmodule : periph_model

// ---- testbench/irq_pc_control_asserts.sv ----
`timescale 1ns/1ps

module irq_pc_control_asserts
    import irq_pc_pkg::*;
#(
    parameter logic [12:0] VECTOR = IRQ_VECTOR
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    input  wire logic [7:0]              reg_rdata,
    input  wire logic                    por_event,
    input  wire logic                    bor_event,
    input  wire logic                    other_reset_event,
    input  wire logic                    call_en,
    input  wire logic                    branch_en,
    input  wire logic [TARGET_WIDTH-1:0] branch_target,
    input  wire logic                    return_en,
    input  wire logic                    exit_with_literal_instr,
    input  wire logic                    interrupt_exit_instr,
    input  wire logic                    irq_entry,
    input  wire logic                    add_w_to_file_instr,
    input  wire logic [7:0]              add_value,
    input  wire logic [PC_WIDTH-1:0]     pc_out,
    input  wire logic                    irq_request
);
    logic rst_ev;
    logic pops;
    logic busy;
    logic low_wr;
    // Actions outranking a low byte write
    assign rst_ev = por_event | bor_event | other_reset_event;
    assign pops   = return_en | exit_with_literal_instr | interrupt_exit_instr;
    assign busy   = rst_ev | irq_entry | call_en | branch_en | pops;
    assign low_wr = reg_write && reg_addr == PC_LOW_OFFSET;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_cause_upper;
        reg_read && reg_addr == RESET_CAUSE_OFFSET |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_cause_upper: assert property (p_cause_upper)
        else $error("cause upper bits");

    property p_event_clear;
        rst_ev |=> pc_out == 13'h0000;
    endproperty
    a_event_clear: assert property (p_event_clear)
        else $error("reset event pc");

    property p_vector;
        irq_entry && !rst_ev |=> pc_out == VECTOR;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector");

    property p_call;
        call_en && !rst_ev && !irq_entry
            |=> pc_out[10:0] == $past(branch_target);
    endproperty
    a_call: assert property (p_call)
        else $error("call target");

    property p_call_return;
        (call_en && !rst_ev && !irq_entry) ##1 !busy
            ##1 (pops && !rst_ev && !irq_entry && !call_en && !branch_en)
            |=> pc_out == $past(pc_out, 3);
    endproperty
    a_call_return: assert property (p_call_return)
        else $error("return value");

    property p_add;
        add_w_to_file_instr && !busy && !low_wr
            |=> pc_out[7:0] == $past(pc_out[7:0]) + $past(add_value);
    endproperty
    a_add: assert property (p_add)
        else $error("computed jump");

    property p_low_write;
        low_wr && !busy |=> pc_out[7:0] == $past(reg_wdata);
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("low byte write");

    property p_low_read;
        reg_read && reg_addr == PC_LOW_OFFSET
            |=> reg_rdata == $past(pc_out[7:0]);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low byte read");

    property p_irq_off;
        (irq_entry && !rst_ev) ##1 !interrupt_exit_instr
            && !(reg_write && reg_addr == IRQ_CONTROL_OFFSET) |=> !irq_request;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("request after entry");
endmodule : irq_pc_control_asserts

bind irq_pc_control irq_pc_control_asserts #(.VECTOR(VECTOR)) checker_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .por_event(por_event), .bor_event(bor_event),
    .other_reset_event(other_reset_event), .call_en(call_en),
    .branch_en(branch_en), .branch_target(branch_target),
    .return_en(return_en), .exit_with_literal_instr(exit_with_literal_instr),
    .interrupt_exit_instr(interrupt_exit_instr), .irq_entry(irq_entry),
    .add_w_to_file_instr(add_w_to_file_instr), .add_value(add_value),
    .pc_out(pc_out), .irq_request(irq_request));

// ---- testbench/irq_pc_control_tb.sv ----
`timescale 1ns/1ps

module irq_pc_control_tb;
    import irq_pc_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rd_exp;
    } row_t;
    localparam logic [10:0] DO_STEP = 11'h001, DO_CALL = 11'h004;
    localparam logic [10:0] DO_RET = 11'h008, DO_IEX = 11'h020;
    localparam logic [10:0] DO_IRQ = 11'h040, DO_ADD = 11'h080;
    localparam logic [10:0] DO_POR = 11'h100, DO_BOR = 11'h200;
    localparam logic [10:0] DO_OTH = 11'h400;
    logic        clk, reset_n, reg_write, reg_read, bcfg, port_rd;
    logic        irq_request;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, add_v, got;
    logic [3:0]  pins, pin_in;
    logic [2:0]  fire, events;
    logic [10:0] ctl, tgt;
    logic [12:0] pc_out;
    logic [12:0] pushed [9];
    int          err_count, compares;
    row_t rows [6] = '{'{8'h0b, 8'h7f, 8'h7f}, '{8'h0c, 8'hff, 8'hff},
        '{8'h8c, 8'hff, 8'hff}, '{8'h8e, 8'hff, 8'h03},
        '{8'h33, 8'hff, 8'h00}, '{8'h0b, 8'h00, 8'h00}};

    periph_model partner (.clk(clk), .fire(fire), .events(events));

    irq_pc_control DUT (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .por_event(ctl[8]), .bor_event(ctl[9]),
        .other_reset_event(ctl[10]), .brownout_detect_config(bcfg),
        .timer_overflow_event(events[0]), .ext_edge_event(events[1]),
        .comparator_event(events[2]), .port_pins(pins),
        .port_inputs(pin_in), .port_read(port_rd), .pc_step(ctl[0]),
        .branch_en(ctl[1]), .call_en(ctl[2]), .branch_target(tgt),
        .return_en(ctl[3]), .exit_with_literal_instr(ctl[4]),
        .interrupt_exit_instr(ctl[5]), .irq_entry(ctl[6]),
        .add_w_to_file_instr(ctl[7]), .add_value(add_v),
        .pc_out(pc_out), .irq_request(irq_request));

    // Free-running clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // One core action, counter checked a cycle later
    task automatic core(input logic [10:0] c, input logic [12:0] exp);
        @(posedge clk);
        ctl <= c;
        @(posedge clk);
        ctl <= '0;
        #1 check(pc_out, exp);
    endtask : core

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        #1;
    endtask : do_reset

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("unexpected at %0t: run took too long", $time);
        complete_run();
    end

    // Main sequence
    initial begin
        {reg_write, reg_read, bcfg, port_rd, reg_addr, reg_wdata} = '0;
        {pins, pin_in, fire, ctl, tgt, add_v} = '0;
        err_count = 0;
        compares = 0;
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, got);
            check(got, rows[i].rd_exp);
        end
        wr(8'h02, 8'h55);
        do_reset();
        check(pc_out, PC_RESET);
        rd(8'h8e, got);
        check(got, 8'h00);
        fire <= 3'h7;
        tick(1);
        fire <= 3'h0;
        tick(3);
        rd(8'h0b, got);
        check(got, 8'h06);
        rd(8'h0c, got);
        check(got, 8'h40);
        check(irq_request, 1'b0);
        wr(8'h0b, 8'ha6);
        tick(2);
        check(irq_request, 1'b1);
        wr(8'h0b, 8'h80);
        wr(8'h8c, 8'h40);
        tick(2);
        check(irq_request, 1'b0);
        wr(8'h0b, 8'hc0);
        tick(2);
        check(irq_request, 1'b1);
        core(DO_IRQ, IRQ_VECTOR);
        tick(2);
        check(irq_request, 1'b0);
        wr(8'h0c, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h0b, 8'h00);
        // Only input pins count
        pin_in <= 4'he;
        pins <= 4'h1;
        tick(3);
        rd(8'h0b, got);
        check(got, 8'h00);
        pins <= 4'h9;
        tick(3);
        rd(8'h0b, got);
        check(got, 8'h01);
        port_rd <= 1'b1;
        tick(1);
        port_rd <= 1'b0;
        tick(2);
        wr(8'h0b, 8'h00);
        rd(8'h0b, got);
        check(got, 8'h00);
        wr(8'h0a, 8'h15);
        wr(8'h02, 8'h34);
        check(pc_out, 13'h1534);
        // Nine calls, nine returns across the wrap
        for (int k = 0; k < 9; k++) begin
            pushed[k] = (k == 0) ? 13'h1534 : {2'b10, 11'(k - 1)};
            tgt <= 11'(k);
            core(DO_CALL, {2'b10, 11'(k)});
        end
        for (int k = 0; k < 9; k++) begin
            core(DO_RET << (k % 3), pushed[k == 8 ? 8 : 8 - k]);
        end
        wr(8'h02, 8'hff);
        check(pc_out, 13'h15ff);
        add_v <= 8'h03;
        core(DO_ADD, 13'h1502);
        rd(8'h02, got);
        check(got, 8'h02);
        core(DO_IRQ, IRQ_VECTOR);
        core(DO_IEX, 13'h1502);
        wr(8'h8e, 8'h03);
        core(DO_POR, 13'h0000);
        rd(8'h8e, got);
        check(got, 8'h01);
        wr(8'h8e, 8'h03);
        bcfg <= 1'b1;
        core(DO_BOR, 13'h0000);
        rd(8'h8e, got);
        check(got, 8'h02);
        core(DO_STEP, 13'h0001);
        core(DO_OTH, 13'h0000);
        rd(8'h8e, got);
        check(got, 8'h02);
        complete_run();
    end
endmodule : irq_pc_control_tb
